// file: common/psa_pkg.sv
package psa_pkg;
  // register indices
  localparam logic [31:0] PSA_IDX_REF_COUNT = 32'h0000_00E7;
  localparam logic [31:0] PSA_IDX_ACT_COUNT = 32'h0000_00E8;
  localparam logic [31:0] PSA_IDX_CUR_POINT = 32'h0000_0198;
  localparam logic [31:0] PSA_IDX_TGT_REQ = 32'h0000_0199;
  localparam logic [31:0] PSA_IDX_MISC_EN = 32'h0000_01A0;
  // field positions and widths
  localparam int PSA_MISC_PSTATE_EN_BIT = 16;
  localparam int PSA_FEAT_FEEDBACK_BIT = 0;
  localparam int PSA_POINT_W = 16;
  localparam int PSA_COUNT_W = 64;
  // reset values
  localparam logic [15:0] PSA_POINT_RST = 16'h0000;
  localparam logic [63:0] PSA_COUNT_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] PSA_MISC_RST = 64'h0000_0000_0000_0000;
  // feature query leaf
  localparam logic [31:0] PSA_FEAT_LEAF = 32'h0000_0006;
  // cycles a transition step takes
  localparam int PSA_STEP_CYCLES = 4;

  typedef enum {
    PSA_IDLE,
    PSA_MOVING
  } psa_state_t;
endpackage

// file: hdl/psa_counter.sv
`timescale 1ns/10ps
module psa_counter #(
  parameter int W = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic inc,
  input wire logic clr,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] value,
  output logic wrap
);
  initial begin
    if (W < 2) $error("counter width too small");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } psa_cnt_st_t;

  psa_cnt_st_t s_q;
  psa_cnt_st_t s_d;

  assign value = s_q.cnt;
  assign wrap = inc && !wr && (s_q.cnt == {W{1'b1}});

  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.cnt = wdata;
    end else if (clr) begin
      s_d.cnt = '0;
    end else if (inc) begin
      s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q.cnt <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: hdl/psa_top.sv
`timescale 1ns/10ps
module psa_top #(
  parameter int STEP_CYCLES = psa_pkg::PSA_STEP_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // model register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_idx,
  input wire logic [63:0] reg_wdata,
  output logic [63:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // feature query
  input wire logic [31:0] feat_leaf,
  output logic [31:0] feat_ecx,
  // activity inputs
  input wire logic active_power_state,
  input wire logic ref_tick,
  input wire logic perf_tick,
  // operating point to the clock and voltage control
  output logic [15:0] point_target,
  output logic point_busy,
  input wire logic point_done
);
  initial begin
    if (STEP_CYCLES < 1) $error("STEP_CYCLES must be at least 1");
  end

  // ***************************************
  // state
  // ***************************************
  typedef struct packed {
    logic [15:0] req;
    logic [15:0] cur;
    logic [15:0] goal;
    logic pending;
    logic pstate_en;
    psa_pkg::psa_state_t fsm;
    logic [31:0] tmr;
    logic [63:0] rdata;
    logic ack;
    logic err;
    logic [31:0] ecx;
  } psa_st_t;

  psa_st_t s_q;
  psa_st_t s_d;

  logic wr_ref;
  logic wr_act;
  logic wrap_ref;
  logic wrap_act;
  logic clr_both;
  logic [63:0] ref_val;
  logic [63:0] act_val;
  logic hit;

  assign hit = (reg_idx == psa_pkg::PSA_IDX_REF_COUNT)
            || (reg_idx == psa_pkg::PSA_IDX_ACT_COUNT)
            || (reg_idx == psa_pkg::PSA_IDX_CUR_POINT)
            || (reg_idx == psa_pkg::PSA_IDX_TGT_REQ)
            || (reg_idx == psa_pkg::PSA_IDX_MISC_EN);
  assign wr_ref = reg_wr && (reg_idx == psa_pkg::PSA_IDX_REF_COUNT);
  assign wr_act = reg_wr && (reg_idx == psa_pkg::PSA_IDX_ACT_COUNT);
  assign clr_both = wrap_ref || wrap_act;

  // ***************************************
  // feedback counters
  // ***************************************
  psa_counter #(.W(psa_pkg::PSA_COUNT_W)) u_ref (
    .mclk(mclk),
    .rst_n(rst_n),
    .inc(active_power_state && ref_tick),
    .clr(clr_both),
    .wr(wr_ref),
    .wdata(reg_wdata),
    .value(ref_val),
    .wrap(wrap_ref)
  );

  psa_counter #(.W(psa_pkg::PSA_COUNT_W)) u_act (
    .mclk(mclk),
    .rst_n(rst_n),
    .inc(active_power_state && perf_tick),
    .clr(clr_both),
    .wr(wr_act),
    .wdata(reg_wdata),
    .value(act_val),
    .wrap(wrap_act)
  );

  // ***************************************
  // register outputs
  // ***************************************
  assign reg_rdata = s_q.rdata;
  assign reg_ack = s_q.ack;
  assign reg_err = s_q.err;
  assign feat_ecx = s_q.ecx;
  assign point_target = s_q.goal;
  assign point_busy = (s_q.fsm == psa_pkg::PSA_MOVING);

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    s_d = s_q;
    s_d.ack = reg_wr || reg_rd;
    s_d.err = (reg_wr || reg_rd) && !hit;
    s_d.ecx = '0;
    if (feat_leaf == psa_pkg::PSA_FEAT_LEAF) begin
      s_d.ecx[psa_pkg::PSA_FEAT_FEEDBACK_BIT] = 1'b1;
    end
    if (reg_wr && reg_idx == psa_pkg::PSA_IDX_TGT_REQ) begin
      s_d.req = reg_wdata[15:0];
      s_d.pending = 1'b1;
    end
    if (reg_wr && reg_idx == psa_pkg::PSA_IDX_MISC_EN) begin
      s_d.pstate_en = reg_wdata[psa_pkg::PSA_MISC_PSTATE_EN_BIT];
    end
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_idx)
        psa_pkg::PSA_IDX_REF_COUNT: s_d.rdata = ref_val;
        psa_pkg::PSA_IDX_ACT_COUNT: s_d.rdata = act_val;
        psa_pkg::PSA_IDX_CUR_POINT: s_d.rdata = {48'h0, s_q.cur};
        psa_pkg::PSA_IDX_TGT_REQ: s_d.rdata = {48'h0, s_q.req};
        psa_pkg::PSA_IDX_MISC_EN: begin
          s_d.rdata[psa_pkg::PSA_MISC_PSTATE_EN_BIT] = s_q.pstate_en;
        end
        default: s_d.rdata = '0;
      endcase
    end
    case (s_q.fsm)
      psa_pkg::PSA_IDLE: begin
        if (s_q.pending && s_q.pstate_en) begin
          s_d.goal = s_q.req;
          s_d.pending = s_d.pending && reg_wr
                        && reg_idx == psa_pkg::PSA_IDX_TGT_REQ;
          s_d.tmr = 32'(STEP_CYCLES - 1);
          s_d.fsm = psa_pkg::PSA_MOVING;
        end
      end
      psa_pkg::PSA_MOVING: begin
        if (s_q.tmr != 32'h0000_0000) begin
          s_d.tmr = s_q.tmr - 32'h0000_0001;
        end else if (point_done) begin
          s_d.cur = s_q.goal;
          s_d.fsm = psa_pkg::PSA_IDLE;
        end
      end
      default: s_d.fsm = psa_pkg::PSA_IDLE;
    endcase
  end

  // ***************************************
  // registers
  // ***************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q.req <= psa_pkg::PSA_POINT_RST;
      s_q.cur <= psa_pkg::PSA_POINT_RST;
      s_q.goal <= psa_pkg::PSA_POINT_RST;
      s_q.pending <= 1'b0;
      s_q.pstate_en <= 1'b0;
      s_q.fsm <= psa_pkg::PSA_IDLE;
      s_q.tmr <= 32'h0000_0000;
      s_q.rdata <= psa_pkg::PSA_COUNT_RST;
      s_q.ack <= 1'b0;
      s_q.err <= 1'b0;
      s_q.ecx <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: test/psa_top_assertions.sv
`timescale 1ns/10ps
// ****
// checker
// ****
module psa_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  // feature query and transition
  input wire logic [31:0] feat_leaf,
  input wire logic [31:0] feat_ecx,
  input wire logic [15:0] point_target,
  input wire logic point_busy,
  input wire logic point_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ack_after_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no ack after access");
  a_no_stray_ack: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
    else $error("ack without access");
  a_err_with_ack: assert property (reg_err |-> reg_ack)
    else $error("error without ack");
  a_rdata_idle_zero: assert property (!reg_ack |-> reg_rdata == 64'h0)
    else $error("read data outside ack");
  a_feat_bit_set: assert property (feat_leaf == 32'h6 |=> feat_ecx[0])
    else $error("feature bit missing");
  a_feat_bit_clr: assert property (feat_leaf != 32'h6 |=> !feat_ecx[0])
    else $error("feature bit on other leaf");
  a_target_held: assert property (
    point_busy && $past(point_busy) |-> $stable(point_target))
    else $error("target moved mid transition");
  a_busy_waits_done: assert property (
    point_busy && !point_done |=> point_busy)
    else $error("busy ended without done");
  c_start: cover property ($rose(point_busy));
  c_finish: cover property ($fell(point_busy));
  c_refused: cover property (reg_err);
endmodule
bind psa_top psa_chk u_chk (.*);

// file: test/psa_top_tb.sv
`timescale 1ns/10ps
module psa_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, point_done = 1'b0;
  logic active_power_state = 1'b0, ref_tick = 1'b0, perf_tick = 1'b0;
  logic [31:0] reg_idx = 32'h0, feat_leaf = 32'h0, feat_ecx;
  logic [31:0] seed = 32'hA9B3C1E0;
  logic [63:0] reg_wdata = 64'h0, reg_rdata, rv, ra;
  logic reg_ack, reg_err, er, point_busy;
  logic [15:0] point_target, c1, c2;
  int n_mismatch = 0, num_checks = 0;
  psa_top #(.STEP_CYCLES(1)) dut (.*);
  always #10 mclk = ~mclk;
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] i,
                     input logic [63:0] d);
    @(negedge mclk);
    reg_wr = w;
    reg_rd = !w;
    reg_idx = i;
    reg_wdata = d;
    @(negedge mclk);
    rv = reg_rdata;
    er = reg_err;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic tick(input logic a, input logic r, input logic p,
                      input int n);
    active_power_state = a;
    ref_tick = r;
    perf_tick = p;
    repeat (n) @(negedge mclk);
    ref_tick = 1'b0;
    perf_tick = 1'b0;
  endtask
  task automatic wt(input logic v);
    for (int k = 0; k < 20 && point_busy !== v; k++) @(negedge mclk);
    chk(point_busy, v);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    acc(0, 32'hE7, 0); chk(rv, 0);
    acc(0, 32'hE8, 0); chk(rv, 0);
    acc(0, 32'h1A0, 0); chk(rv, 0);
    acc(1, 32'h123, 64'hF); chk(er, 1);
    acc(0, 32'h123, 0); chk(rv, 0);
    chk(er, 1);
    feat_leaf = 32'h6;
    repeat (2) @(negedge mclk);
    chk(feat_ecx[0], 1);
    feat_leaf = 32'h7;
    repeat (2) @(negedge mclk);
    chk(feat_ecx[0], 0);
    seed = xs(seed);
    ra = {seed, ~seed};
    acc(1, 32'hE7, ra);
    acc(0, 32'hE7, 0); chk(rv, ra);
    acc(0, 32'hE8, 0); chk(rv, 0);
    tick(0, 1, 1, 5);
    acc(0, 32'hE7, 0); chk(rv, ra);
    tick(1, 1, 0, seed[3:0] + 1);
    acc(0, 32'hE7, 0); chk(rv, ra + seed[3:0] + 1);
    acc(0, 32'hE8, 0); chk(rv, 0);
    tick(1, 0, 1, 3);
    acc(0, 32'hE8, 0); chk(rv, 3);
    acc(1, 32'hE8, 64'hFFFF_FFFF_FFFF_FFFF);
    tick(1, 0, 1, 1);
    acc(0, 32'hE7, 0); chk(rv, 0);
    acc(0, 32'hE8, 0); chk(rv, 0);
    chk(rv < ra, 1);
    acc(1, 32'hE7, 0);
    acc(1, 32'hE8, 0);
    tick(1, 1, 1, 4);
    acc(0, 32'hE7, 0); chk(rv, 4);
    ra = rv;
    acc(0, 32'hE8, 0); chk(rv, ra);
    seed = xs(seed);
    c1 = seed[15:0];
    c2 = seed[31:16];
    acc(1, 32'h199, {seed, seed});
    acc(0, 32'h199, 0); chk(rv, c1);
    chk(point_busy, 0);
    acc(1, 32'h1A0, 64'h1_0000);
    wt(1);
    chk(point_target, c1);
    acc(1, 32'h199, c2);
    acc(0, 32'h199, 0); chk(rv, c2);
    acc(0, 32'h198, 0); chk(rv, 0);
    point_done = 1'b1;
    wt(0);
    point_done = 1'b0;
    acc(0, 32'h198, 0); chk(rv, c1);
    wt(1);
    chk(point_target, c2);
    point_done = 1'b1;
    wt(0);
    point_done = 1'b0;
    acc(0, 32'h198, 0); chk(rv, c2);
    summarize();
  end
endmodule
